// File: startup_seq_pkg.sv
// Constants, types and helper functions for the start-up sequencer.
// Functional notes
// (R1) Delay code 0..7 means 2**code time units; 4..7 give 16, 32, 64, 128.
// (R2) Delay count sets run-on time after a fault or spacing between restarts.
// (R3) Hold a 16-bit output-voltage level at which power-good asserts.
// (R4) Below the release level, drop power-good if pin-enabled and set status bit.
// (R5) Wait the programmed turn-on delay in ms from enable before rising.
// (R6) After the turn-on delay, ramp the output over the programmed rise time.
// (R7) Flag a start-up timeout when the output misses the undervoltage limit in time.
// (R8) A start-up timeout limit of zero means no limit at all.
// (R9) Response 00 ignores the timeout fault and keeps operating.
// (R10) Response 01 runs on for the delay, then applies retry setting if still faulty.
// (R11) Response 10 disables the output and then applies the retry setting.
// (R12) Response 11 stays off until status clear, clear-all, reset or off-on cycle.
// (R13) Retry setting 000 never restarts; output stays off until the fault clears.
// (R14) Retry settings 001..011 allow one to three restarts, then stay off.
// (R15) Restart attempts start one delay count times the fault time unit apart.
// (R16) All four response codes are supported here; none is rejected.
// (R17) Retry settings 100..110 allow four to six restarts, then stay off.
// (R18) Retry setting 111 retries forever until commanded off or shut down.
// (R19) Restart counter clears on fault clear or on a new enable sequence; the code clears it on a fault clear only in ST_LATCHED.
// (R20) Host sets release below assert level and programs before enabling.
package startup_seq_pkg;
    localparam logic [7:0] ADDR_PG_ASSERT = 8'h5E;
    localparam logic [7:0] ADDR_PG_RELEASE = 8'h5F;
    localparam logic [7:0] ADDR_ON_WAIT = 8'h60;
    localparam logic [7:0] ADDR_ON_RAMP = 8'h61;
    localparam logic [7:0] ADDR_TMO_LIMIT = 8'h62;
    localparam logic [7:0] ADDR_TMO_ACTION = 8'h63;

    localparam logic [15:0] RST_LEVEL = 16'h0000;
    localparam logic [15:0] RST_TIME = 16'h0000;
    localparam logic [7:0] RST_ACTION = 8'h00;

    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DLY_HI = 2;
    localparam int DLY_LO = 0;
    localparam int LIN_EXP_LO = 11;
    localparam int LIN_SIGN = 10;

    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_RUN_ON = 2'h1;
    localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
    localparam logic [1:0] RESP_LATCH_OFF = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 24;

    typedef logic [TMR_W-1:0] ms_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DELAY = 3'h1,
        ST_RISE = 3'h3,
        ST_ON = 3'h2,
        ST_RUN_ON = 3'h6,
        ST_RETRY_WAIT = 3'h7,
        ST_LATCHED = 3'h5
    } seq_state_e;

    // Linear format to whole milliseconds; negative values read as zero, overflow saturates.
    function automatic ms_t lin_to_ms(input logic [15:0] v);
        logic signed [4:0] e;
        logic [4:0] sh;
        logic [47:0] w;
        e = signed'(v[15:LIN_EXP_LO]);
        sh = '0;
        w = '0;
        if (v[LIN_SIGN])
            return '0;
        if (e < 0)
        begin
            sh = 5'(-e);
            w = {37'h0, v[LIN_SIGN:0]} >> sh;
        end
        else
        begin
            sh = 5'(e);
            w = {37'h0, v[LIN_SIGN:0]} << sh;
        end
        if (w[47:TMR_W] != '0)
            return '1;
        return w[TMR_W-1:0];
    endfunction

    // Delay code selects a power-of-two count of fault time units.
    function automatic ms_t delay_ms(input logic [2:0] code, input logic [7:0] unit_ms);
        return ms_t'({16'h0, unit_ms} << code); // R1 R2
    endfunction
endpackage

// File: ms_ticker.sv
// Millisecond tick generator from the core clock.
`timescale 1ns/10ps
module ms_ticker #(
    parameter int CYCLES = 100000
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // One-cycle pulse every millisecond.
    output logic tick
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic tick_d;

    always_comb
    begin
        tick_d = (cnt_q == 32'(CYCLES - 1));
        cnt_d = tick_d ? 32'h0 : cnt_q + 32'h1;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_q <= 32'h0;
            tick <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule

// File: startup_sequencer.sv
// Output start-up sequencer with power-good and start-up timeout fault handling.
`timescale 1ns/10ps
module startup_sequencer #(
    parameter int CYCLES_PER_MS = startup_seq_pkg::MS_CYCLES
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // Command register port.
    input wire logic reg_wr,
    input wire logic [7:0] reg_cmd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata_q,
    // Control and fault clearing.
    input wire logic enable_pin,
    input wire logic clear_faults,
    input wire logic clear_timeout_bit,
    // Measurements and settings held elsewhere.
    input wire logic [15:0] vout_meas,
    input wire logic [15:0] uv_fault_limit,
    input wire logic [7:0] fault_unit_ms,
    input wire logic pg_pin_enable,
    // Outputs.
    output logic output_enable_q,
    output logic ramp_active_q,
    output logic power_ok_output_q,
    output logic pg_status_q,
    output logic timeout_fault_q,
    output logic [2:0] retry_count_q
);
    import startup_seq_pkg::*;

    logic tick;
    logic en_meta_q;
    logic en_s_q;
    logic en_prev_q;

    logic [15:0] pg_assert_level_q, pg_assert_level_d;
    logic [15:0] pg_release_level_q, pg_release_level_d;
    logic [15:0] turn_on_wait_q, turn_on_wait_d;
    logic [15:0] turn_on_ramp_q, turn_on_ramp_d;
    logic [15:0] startup_timeout_limit_q, startup_timeout_limit_d;
    logic [7:0] startup_timeout_action_q, startup_timeout_action_d;
    logic [15:0] rdata_d;

    seq_state_e state_q, state_d;
    ms_t tmr_q, tmr_d;
    ms_t up_ms_q, up_ms_d;
    logic reached_q, reached_d;
    logic tmo_done_q, tmo_done_d;
    logic fault_d;
    logic [2:0] retry_d;
    logic pg_q, pg_d;

    logic [1:0] resp;
    logic [2:0] retries;
    ms_t fault_dly;
    logic tmo_evt;
    logic clr;
    logic off_evt;

    ms_ticker #(
        .CYCLES(CYCLES_PER_MS)
    ) u_ticker (
        .core_clk(core_clk),
        .rstn(rstn),
        .tick(tick)
    );

    // Enable pin comes from outside; two flops before use.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            en_meta_q <= 1'b0;
            en_s_q <= 1'b0;
            en_prev_q <= 1'b0;
        end
        else
        begin
            en_meta_q <= enable_pin;
            en_s_q <= en_meta_q;
            en_prev_q <= en_s_q;
        end
    end

    // Register writes and reads.
    always_comb
    begin
        pg_assert_level_d = pg_assert_level_q;
        pg_release_level_d = pg_release_level_q;
        turn_on_wait_d = turn_on_wait_q;
        turn_on_ramp_d = turn_on_ramp_q;
        startup_timeout_limit_d = startup_timeout_limit_q;
        startup_timeout_action_d = startup_timeout_action_q;
        if (reg_wr)
        begin
            case (reg_cmd)
                ADDR_PG_ASSERT: pg_assert_level_d = reg_wdata; // R3
                ADDR_PG_RELEASE: pg_release_level_d = reg_wdata; // R4
                ADDR_ON_WAIT: turn_on_wait_d = reg_wdata; // R5
                ADDR_ON_RAMP: turn_on_ramp_d = reg_wdata; // R6
                ADDR_TMO_LIMIT: startup_timeout_limit_d = reg_wdata; // R7
                ADDR_TMO_ACTION: startup_timeout_action_d = reg_wdata[7:0];
                default: ;
            endcase
        end
        case (reg_cmd)
            ADDR_PG_ASSERT: rdata_d = pg_assert_level_q;
            ADDR_PG_RELEASE: rdata_d = pg_release_level_q;
            ADDR_ON_WAIT: rdata_d = turn_on_wait_q;
            ADDR_ON_RAMP: rdata_d = turn_on_ramp_q;
            ADDR_TMO_LIMIT: rdata_d = startup_timeout_limit_q;
            ADDR_TMO_ACTION: rdata_d = {8'h00, startup_timeout_action_q};
            default: rdata_d = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pg_assert_level_q <= RST_LEVEL;
            pg_release_level_q <= RST_LEVEL;
            turn_on_wait_q <= RST_TIME;
            turn_on_ramp_q <= RST_TIME;
            startup_timeout_limit_q <= RST_TIME;
            startup_timeout_action_q <= RST_ACTION;
            reg_rdata_q <= 16'h0000;
        end
        else
        begin
            pg_assert_level_q <= pg_assert_level_d;
            pg_release_level_q <= pg_release_level_d;
            turn_on_wait_q <= turn_on_wait_d;
            turn_on_ramp_q <= turn_on_ramp_d;
            startup_timeout_limit_q <= startup_timeout_limit_d;
            startup_timeout_action_q <= startup_timeout_action_d;
            reg_rdata_q <= rdata_d;
        end
    end

    // Next state after a fault that calls for the retry setting.
    function automatic seq_state_e retry_next(input logic [2:0] setting, input logic [2:0] done);
        if (setting == RETRY_NONE)
            return ST_LATCHED; // R13
        if (setting == RETRY_FOREVER)
            return ST_RETRY_WAIT; // R18
        if (done < setting)
            return ST_RETRY_WAIT; // R14 R17
        return ST_LATCHED; // R14 R17
    endfunction

    // Sequencing and fault response.
    always_comb
    begin
        resp = startup_timeout_action_q[RESP_HI:RESP_LO];
        retries = startup_timeout_action_q[RETRY_HI:RETRY_LO];
        fault_dly = delay_ms(startup_timeout_action_q[DLY_HI:DLY_LO], fault_unit_ms); // R2
        clr = clear_faults | clear_timeout_bit;
        off_evt = en_prev_q & ~en_s_q;
        state_d = state_q;
        tmr_d = tick ? tmr_q + ms_t'(1) : tmr_q;
        up_ms_d = up_ms_q;
        reached_d = reached_q;
        tmo_done_d = tmo_done_q;
        retry_d = retry_count_q;
        tmo_evt = 1'b0;
        if (state_q == ST_DELAY || state_q == ST_RISE || state_q == ST_ON || state_q == ST_RUN_ON)
        begin
            if (tick && !reached_q)
                up_ms_d = up_ms_q + ms_t'(1);
            if (output_enable_q && vout_meas >= uv_fault_limit)
                reached_d = 1'b1;
            tmo_evt = (startup_timeout_limit_q != RST_TIME) && !reached_q && !tmo_done_q && // R8
                      (up_ms_q >= lin_to_ms(startup_timeout_limit_q)); // R7
        end
        if (tmo_evt)
            tmo_done_d = 1'b1;
        case (state_q)
            ST_IDLE:
            begin
                if (en_s_q)
                begin
                    state_d = ST_DELAY;
                    tmr_d = '0;
                    up_ms_d = '0;
                    reached_d = 1'b0;
                    tmo_done_d = 1'b0;
                    retry_d = 3'h0; // R19
                end
            end
            ST_DELAY:
            begin
                if (tmr_q >= lin_to_ms(turn_on_wait_q))
                begin
                    state_d = ST_RISE; // R5
                    tmr_d = '0;
                end
            end
            ST_RISE:
            begin
                if (tmr_q >= lin_to_ms(turn_on_ramp_q))
                    state_d = ST_ON; // R6
            end
            ST_ON: ;
            ST_RUN_ON:
            begin
                if (reached_q)
                    state_d = ST_ON;
                else if (tmr_q >= fault_dly)
                begin
                    state_d = retry_next(retries, retry_count_q); // R10
                    tmr_d = '0;
                end
            end
            ST_RETRY_WAIT:
            begin
                if (tmr_q >= fault_dly)
                begin
                    state_d = ST_DELAY; // R15
                    tmr_d = '0;
                    up_ms_d = '0;
                    reached_d = 1'b0;
                    tmo_done_d = 1'b0;
                    if (retries != RETRY_FOREVER)
                        retry_d = retry_count_q + 3'h1;
                end
            end
            ST_LATCHED:
            begin
                if (clr)
                begin
                    state_d = ST_IDLE; // R12 R13
                    retry_d = 3'h0; // R19
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (tmo_evt && state_q != ST_RUN_ON)
        begin
            if (resp != RESP_IGNORE)
                tmr_d = '0;
            case (resp) // R16
                RESP_IGNORE: ; // R9
                RESP_RUN_ON: state_d = ST_RUN_ON; // R10
                RESP_DISABLE_RETRY: state_d = retry_next(retries, retry_count_q); // R11
                RESP_LATCH_OFF: state_d = ST_LATCHED; // R12
                default: ;
            endcase
        end
        if (!en_s_q)
            state_d = ST_IDLE; // R18
        // A new timeout wins over a clear in the same cycle; an off command clears it too.
        fault_d = tmo_evt | (timeout_fault_q & ~clr & ~off_evt); // R7 R12
    end

    // Power-good with hysteresis between assert and release levels.
    always_comb
    begin
        pg_d = pg_q;
        if (!output_enable_q)
            pg_d = 1'b0;
        else if (vout_meas >= pg_assert_level_q)
            pg_d = 1'b1; // R3
        else if (vout_meas < pg_release_level_q)
            pg_d = 1'b0; // R4
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= ST_IDLE;
            tmr_q <= '0;
            up_ms_q <= '0;
            reached_q <= 1'b0;
            tmo_done_q <= 1'b0;
            retry_count_q <= 3'h0;
            timeout_fault_q <= 1'b0;
            output_enable_q <= 1'b0;
            ramp_active_q <= 1'b0;
            pg_q <= 1'b0;
            power_ok_output_q <= 1'b0;
            pg_status_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            up_ms_q <= up_ms_d;
            reached_q <= reached_d;
            tmo_done_q <= tmo_done_d;
            retry_count_q <= retry_d;
            timeout_fault_q <= fault_d;
            output_enable_q <= (state_d == ST_RISE) || (state_d == ST_ON) || (state_d == ST_RUN_ON); // R11
            ramp_active_q <= (state_d == ST_RISE); // R6
            pg_q <= pg_d;
            power_ok_output_q <= pg_d & pg_pin_enable; // R4
            pg_status_q <= ~pg_d; // R4
        end
    end
endmodule

// File: seq_checker_assertions.sv
// Concurrent checks on the start-up sequencer's ports.
`timescale 1ns/10ps
module seq_checker_assertions #(
    parameter int CYCLES_PER_MS = 10
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // Register writes.
    input wire logic reg_wr,
    input wire logic [7:0] reg_cmd,
    input wire logic [15:0] reg_wdata,
    // Control and outputs.
    input wire logic enable_pin,
    input wire logic output_enable_q,
    input wire logic ramp_active_q,
    input wire logic power_ok_output_q,
    input wire logic pg_status_q,
    input wire logic timeout_fault_q,
    input wire logic [2:0] retry_count_q
);
    logic [7:0] act_q;
    logic [15:0] lim_q;

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // Shadow copies of the fault settings as last written.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            act_q <= 8'h00;
            lim_q <= 16'h0000;
        end
        else if (reg_wr && reg_cmd == 8'h63)
            act_q <= reg_wdata[7:0];
        else if (reg_wr && reg_cmd == 8'h62)
            lim_q <= reg_wdata;
    end

    sequence fault_seen;
        $rose(timeout_fault_q) && $past(output_enable_q);
    endsequence

    ramp_needs_output_a: assert property (ramp_active_q |-> output_enable_q)
        else $error("ramp active while output off");
    rise_starts_ramp_a: assert property ($rose(output_enable_q) |-> ramp_active_q)
        else $error("output on without ramp");
    turn_on_cause_a: assert property ($rose(output_enable_q) |-> $past(enable_pin, 3))
        else $error("output on without enable");
    pg_off_level_a: assert property (!output_enable_q |-> ##[0:1] !power_ok_output_q)
        else $error("power good while output off");
    pg_status_agree_a: assert property (power_ok_output_q |-> !pg_status_q)
        else $error("status bit disagrees with power good");
    enable_off_a: assert property (!enable_pin [*6] |-> !output_enable_q)
        else $error("output on while enable low");
    zero_limit_a: assert property (lim_q == 16'h0000 |-> !$rose(timeout_fault_q))
        else $error("timeout fault with zero limit");
    ignore_keeps_a: assert property (act_q[7:6] == 2'h0 ##0 fault_seen |-> output_enable_q [*4])
        else $error("ignored fault disturbed output");
    run_on_keeps_a: assert property (act_q[7:6] == 2'h1 ##0 fault_seen |-> output_enable_q [*8])
        else $error("run-on output dropped early");
    disable_fault_a: assert property (act_q[7] ##0 fault_seen |-> ##[0:2] !output_enable_q)
        else $error("output not disabled on fault");
    retry_bound_a: assert property (output_enable_q && act_q[5:3] != 3'h7 |-> retry_count_q <= act_q[5:3])
        else $error("retry count above setting");
endmodule

bind startup_sequencer seq_checker_assertions #(.CYCLES_PER_MS(CYCLES_PER_MS)) checker_i (.core_clk, .rstn,
    .reg_wr, .reg_cmd, .reg_wdata, .enable_pin, .output_enable_q, .ramp_active_q, .power_ok_output_q,
    .pg_status_q, .timeout_fault_q, .retry_count_q);

// File: seq_host.sv
// Host model that writes and reads the sequencer's command registers.
`timescale 1ns/10ps
module seq_host (
    // Clock.
    input wire logic core_clk,
    // Command register port.
    output logic reg_wr,
    output logic [7:0] reg_cmd,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata_q
);
    initial
    begin
        reg_wr = 1'b0;
        reg_cmd = 8'h00;
        reg_wdata = 16'h0000;
    end

    // Callers program only while the output is off; prog puts the release level below the assert level.
    task automatic put(input logic [7:0] cmd, input logic [15:0] data);
        @(posedge core_clk);
        #1;
        reg_cmd = cmd;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~data;
    endtask

    task automatic get(input logic [7:0] cmd, output logic [15:0] data);
        @(posedge core_clk);
        #1;
        reg_cmd = cmd;
        @(posedge core_clk);
        #1;
        data = reg_rdata_q;
    endtask
endmodule

// File: startup_sequence_fault_retry_bench.sv
// Self-checking bench for the start-up sequencer.
`timescale 1ns/10ps
module startup_sequence_fault_retry_bench;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr;
    logic [7:0] reg_cmd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata_q;
    logic enable = 1'b0;
    logic clr_all = 1'b0;
    logic clr_bit = 1'b0;
    logic [15:0] vout = 16'h0000;
    logic pg_en = 1'b1;
    logic output_enable_q, ramp_active_q, power_ok_output_q, pg_status_q, timeout_fault_q;
    logic [2:0] retry_count_q;
    logic was_on = 1'b0;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int rises = 0;
    int off_n = 0;
    int gap_n = 0;

    always #5 core_clk = ~core_clk;

    seq_host host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q));

    startup_sequencer #(.CYCLES_PER_MS(10)) dut (.core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr),
        .reg_cmd(reg_cmd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .enable_pin(enable),
        .clear_faults(clr_all), .clear_timeout_bit(clr_bit), .vout_meas(vout), .uv_fault_limit(16'h00A0),
        .fault_unit_ms(8'h01), .pg_pin_enable(pg_en), .output_enable_q(output_enable_q),
        .ramp_active_q(ramp_active_q), .power_ok_output_q(power_ok_output_q), .pg_status_q(pg_status_q),
        .timeout_fault_q(timeout_fault_q), .retry_count_q(retry_count_q));

    // Counts output starts and how long the output was off before each one.
    always @(posedge core_clk)
    begin
        cyc++;
        if (output_enable_q === 1'b1 && !was_on)
        begin
            rises++;
            gap_n = off_n;
        end
        off_n = (output_enable_q === 1'b1) ? 0 : off_n + 1;
        was_on = (output_enable_q === 1'b1);
        if (cyc == 30000)
        begin
            fail_count++;
            results();
        end
    end

    task automatic results();
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic check(input logic ok, input string what);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic wait_on(input logic v, input int lim);
        for (int i = 0; i < lim && output_enable_q !== v; i++)
            step(1);
        check(output_enable_q === v, "output enable level");
    endtask

    task automatic prog(input logic [15:0] lim, input logic [7:0] act, input logic [15:0] dly, input logic [15:0] rmp);
        host.put(8'h5E, 16'h0100);
        host.put(8'h5F, 16'h0080);
        host.put(8'h60, dly);
        host.put(8'h61, rmp);
        host.put(8'h62, lim);
        host.put(8'h63, {8'h00, act});
    endtask

    task automatic t_regs();
        logic [15:0] d;
        for (int a = 8'h5E; a <= 8'h63; a++)
        begin
            host.get(8'(a), d);
            check(d === 16'h0000, "reset value");
            host.put(8'(a), {8'(a), 8'hA5});
            host.get(8'(a), d);
            check(d === ((a == 8'h63) ? 16'h00A5 : {8'(a), 8'hA5}), "readback");
        end
        host.put(8'h70, 16'hFFFF);
        host.get(8'h70, d);
        check(d === 16'h0000, "unmapped read");
        $display("test registers done");
    endtask

    task automatic t_start();
        int n;
        prog(16'h0000, 8'h00, 16'h0002, 16'h0003);
        enable = 1'b1;
        n = cyc;
        wait_on(1'b1, 100);
        check(cyc - n >= 12 && cyc - n <= 27, "turn-on delay");
        n = cyc;
        for (int i = 0; i < 60 && ramp_active_q === 1'b1; i++)
            step(1);
        check(cyc - n >= 20 && cyc - n <= 32 && output_enable_q === 1'b1, "rise time");
        vout = 16'h0100;
        step(3);
        check(power_ok_output_q === 1'b1 && pg_status_q === 1'b0, "power good on");
        pg_en = 1'b0;
        step(3);
        check(power_ok_output_q === 1'b0 && pg_status_q === 1'b0, "power good pin disabled");
        pg_en = 1'b1;
        vout = 16'h00C0;
        step(3);
        check(power_ok_output_q === 1'b1, "power good hold");
        vout = 16'h007F;
        step(3);
        check(power_ok_output_q === 1'b0 && pg_status_q === 1'b1, "power good off");
        step(60);
        check(timeout_fault_q === 1'b0, "unlimited start-up");
        enable = 1'b0;
        wait_on(1'b0, 8);
        $display("test start-up done");
    endtask

    task automatic t_ignore();
        prog(16'h0002, 8'h00, 16'h0000, 16'h0000);
        rises = 0;
        enable = 1'b1;
        for (int i = 0; i < 100 && timeout_fault_q !== 1'b1; i++)
            step(1);
        step(20);
        check(timeout_fault_q === 1'b1 && output_enable_q === 1'b1 && rises == 1, "ignored fault");
        enable = 1'b0;
        wait_on(1'b0, 8);
        check(timeout_fault_q === 1'b0, "off clears fault");
        $display("test ignore done");
    endtask

    task automatic t_recover();
        prog(16'h0002, 8'h4A, 16'h0000, 16'h0000);
        rises = 0;
        enable = 1'b1;
        for (int i = 0; i < 100 && timeout_fault_q !== 1'b1; i++)
            step(1);
        vout = 16'h0100;
        step(80);
        check(output_enable_q === 1'b1 && ramp_active_q === 1'b0 && rises == 1, "run-on recovery");
        vout = 16'h0000;
        enable = 1'b0;
        wait_on(1'b0, 8);
        $display("test run-on recovery done");
    endtask

    task automatic t_retry(input logic [1:0] resp, input logic [2:0] rs, input logic [2:0] code, input int exp);
        int gap;
        gap = 10 * (1 << code);
        prog(16'h0002, {resp, rs, code}, 16'h0000, 16'h0000);
        rises = 0;
        enable = 1'b1;
        wait_on(1'b1, 20);
        for (int i = 0; i < 4000 && off_n < 250; i++)
            step(1);
        check(rises == exp && timeout_fault_q === 1'b1, "restart attempts");
        check(retry_count_q === ((resp == 2'h3) ? 3'h0 : rs), "retry count");
        if (exp > 1)
            check(gap_n >= gap - 10 && gap_n <= gap + 5, "retry spacing");
        clr_bit = rs[0];
        clr_all = !rs[0];
        step(1);
        clr_bit = 1'b0;
        clr_all = 1'b0;
        wait_on(1'b1, 60);
        check(retry_count_q === 3'h0 && timeout_fault_q === 1'b0, "cleared restart");
        enable = 1'b0;
        wait_on(1'b0, 8);
        $display("test retry %0d/%0d done", resp, rs);
    endtask

    task automatic t_forever();
        prog(16'h0002, 8'hB9, 16'h0000, 16'h0000);
        rises = 0;
        enable = 1'b1;
        for (int i = 0; i < 1500 && rises < 8; i++)
            step(1);
        check(rises >= 8, "endless retry");
        enable = 1'b0;
        wait_on(1'b0, 8);
        step(40);
        check(output_enable_q === 1'b0, "commanded off");
        $display("test endless retry done");
    endtask

    initial
    begin
        step(10);
        rstn = 1'b1;
        t_regs();
        t_start();
        t_ignore();
        t_recover();
        for (int r = 0; r < 7; r++)
            t_retry(2'h2, 3'(r), (r == 1) ? 3'h4 : 3'h2, r + 1);
        t_retry(2'h1, 3'h1, 3'h2, 2);
        t_retry(2'h3, 3'h3, 3'h2, 1);
        t_forever();
        results();
    end
endmodule
